// *** design/dsp_pkg.sv ***
// Shared constants and carrier types for the divide step datapath
package dsp_pkg;
    localparam int W = 16;
    // Status register bit positions
    localparam int ST_AZ_BIT = 0;
    localparam int ST_AN_BIT = 1;
    localparam int ST_AV_BIT = 2;
    localparam int ST_AC_BIT = 3;
    localparam int ST_AS_BIT = 4;
    localparam int ST_AQ_BIT = 5;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [15:0] MOST_NEG = 16'h8000;
    localparam logic [15:0] UNSIGNED_MAX_DIVISOR = 16'h7FFF;
    localparam logic [7:0] OVERFLOW_WRITE = 8'h04;
    localparam int SIGNED_QSTEPS = 15;
    localparam int UNSIGNED_QSTEPS = 16;
    localparam int STEP_CYCLES = 1;

    typedef enum logic [2:0] {
        DSP_OP_NONE = 3'b000,
        DSP_OP_SIGN = 3'b001,
        DSP_OP_QBIT = 3'b010,
        DSP_OP_ABS = 3'b011,
        DSP_OP_STAT_WR = 3'b100,
        DSP_OP_LOAD = 3'b101,
        DSP_OP_MID_WR = 3'b110
    } dsp_op_t;

    // One sequencer request per cycle
    typedef struct packed {
        dsp_op_t op;
        logic [15:0] x_operand;
        logic [15:0] y_high;
        logic [15:0] y_low;
        logic [15:0] wdata;
    } dsp_req_t;

    // Partial remainder pair after a step
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } dsp_rem_t;
endpackage

// *** design/dsp_step_core.sv ***
// Combinational divide step: sign step and quotient bit step
`timescale 1ns/1ps
module dsp_step_core (
    input wire logic sign_step,
    input wire logic [15:0] divisor,
    input wire logic [15:0] rem_high,
    input wire logic [15:0] rem_low,
    input wire logic quotient_bit_flag,
    output logic [15:0] new_high,
    output logic [15:0] new_low,
    output logic new_flag,
    output logic sum_ovf
);
    logic [15:0] sum;
    logic [15:0] operand;
    always_comb begin
        operand = quotient_bit_flag ? divisor : ~divisor;
        sum = rem_high + operand + {15'h0000, ~quotient_bit_flag};
        sum_ovf = (rem_high[15] == operand[15]) && (sum[15] != rem_high[15]);
        if (sign_step) begin
            new_flag = rem_high[15] ^ divisor[15];
            new_high = {rem_high[14:0], rem_low[15]};
            new_low = {rem_low[14:0], new_flag};
            sum_ovf = 1'b0;
        end else begin
            // Divisor sign is not corrected for: negative divisors come out one LSB low, except a true quotient of 8000h
            new_flag = divisor[15] ^ sum[15];
            new_high = {sum[14:0], rem_low[15]};
            new_low = {rem_low[14:0], ~new_flag};
        end
    end
endmodule

// *** design/dsp_divide_step.sv ***
// Divide step datapath: remainder registers, status flags, product words
`timescale 1ns/1ps
module dsp_divide_step (
    input wire logic mclk,
    input wire logic rst,
    input wire dsp_pkg::dsp_req_t req,
    output dsp_pkg::dsp_rem_t remainder,
    output logic [7:0] alu_status_register,
    output logic quotient_bit_flag,
    output logic alu_overflow_flag,
    output logic [15:0] alu_result,
    output logic [15:0] product_middle_word,
    output logic [15:0] product_top_word,
    output logic unsigned_divisor_invalid
);
    // Remainder group: feedback word and low dividend word
    logic [15:0] alu_feedback_reg_r, alu_feedback_reg_nxt;
    logic [15:0] dividend_low_reg_r, dividend_low_reg_nxt;
    // Range flag of the divisor that the last step or load carried
    logic divisor_invalid_r, divisor_invalid_nxt;
    // Status group
    logic [7:0] status_r, status_nxt;
    // Absolute value group
    logic [15:0] result_r, result_nxt;
    // Product word group
    logic [15:0] mid_r, mid_nxt;
    logic [15:0] top_r, top_nxt;
    wire [15:0] top_fill;
    // Shared decode and datapath nets
    logic [15:0] neg_x;
    logic [15:0] abs_value;
    logic [15:0] step_high;
    logic [15:0] step_low;
    logic step_flag;
    logic step_ovf;
    logic is_sign;
    logic is_qbit;
    logic is_step;
    logic is_abs;
    logic is_stat_wr;
    logic is_load;
    logic is_mid_wr;

    // One decode feeds every group; code 7 is unused and does nothing
    always_comb begin
        is_sign = 1'b0;
        is_qbit = 1'b0;
        is_abs = 1'b0;
        is_stat_wr = 1'b0;
        is_load = 1'b0;
        is_mid_wr = 1'b0;
        unique case (req.op)
            dsp_pkg::DSP_OP_NONE: begin
            end
            dsp_pkg::DSP_OP_SIGN: begin
                is_sign = 1'b1;
            end
            dsp_pkg::DSP_OP_QBIT: begin
                is_qbit = 1'b1;
            end
            dsp_pkg::DSP_OP_ABS: begin
                is_abs = 1'b1;
            end
            dsp_pkg::DSP_OP_STAT_WR: begin
                is_stat_wr = 1'b1;
            end
            dsp_pkg::DSP_OP_LOAD: begin
                is_load = 1'b1;
            end
            dsp_pkg::DSP_OP_MID_WR: begin
                is_mid_wr = 1'b1;
            end
            default: begin
            end
        endcase
    end
    assign is_step = is_sign || is_qbit;
    // Negating 8000h wraps back to 8000h; the overflow flag is what reports it
    assign neg_x = 16'h0000 - req.x_operand;
    assign abs_value = req.x_operand[15] ? neg_x : req.x_operand;

    // Each bit of the top word is a copy of the written sign bit
    for (genvar b = 0; b < dsp_pkg::W; b++) begin : g_top_fill
        assign top_fill[b] = req.wdata[15];
    end

    // Sign step reads the high word from the request, bit steps from the feedback register
    dsp_step_core u_core (
        .sign_step(is_sign),
        .divisor(req.x_operand),
        .rem_high(is_sign ? req.y_high : alu_feedback_reg_r),
        .rem_low(is_sign ? req.y_low : dividend_low_reg_r),
        .quotient_bit_flag(status_r[dsp_pkg::ST_AQ_BIT]),
        .new_high(step_high),
        .new_low(step_low),
        .new_flag(step_flag),
        .sum_ovf(step_ovf)
    );

    // Remainder group: only the two steps and the plain load write it
    always_comb begin
        alu_feedback_reg_nxt = alu_feedback_reg_r;
        dividend_low_reg_nxt = dividend_low_reg_r;
        divisor_invalid_nxt = divisor_invalid_r;
        if (is_step) begin
            alu_feedback_reg_nxt = step_high;
            // A true quotient of 8000h falls out of the flag chain exact, no LSB loss
            dividend_low_reg_nxt = step_low;
            // Flagged, not fixed: the caller has to pre-shift both operands instead
            divisor_invalid_nxt = (req.x_operand > dsp_pkg::UNSIGNED_MAX_DIVISOR);
        end else if (is_load) begin
            alu_feedback_reg_nxt = req.y_high;
            dividend_low_reg_nxt = req.y_low;
            divisor_invalid_nxt = (req.x_operand > dsp_pkg::UNSIGNED_MAX_DIVISOR);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alu_feedback_reg_r <= dsp_pkg::WORD_RST;
            dividend_low_reg_r <= dsp_pkg::WORD_RST;
            divisor_invalid_r <= dsp_pkg::FLAG_RST;
        end else begin
            alu_feedback_reg_r <= alu_feedback_reg_nxt;
            dividend_low_reg_r <= dividend_low_reg_nxt;
            divisor_invalid_r <= divisor_invalid_nxt;
        end
    end

    // Status group: steps own the quotient flag, absolute value the result flags
    always_comb begin
        status_nxt = status_r;
        if (is_step) begin
            status_nxt[dsp_pkg::ST_AQ_BIT] = step_flag;
            // Sticky until a status write or an absolute value operation rewrites it
            if (step_ovf) begin
                status_nxt[dsp_pkg::ST_AV_BIT] = 1'b1;
            end
            if (is_sign) begin
                status_nxt[dsp_pkg::ST_AS_BIT] = req.x_operand[15];
            end
        end else if (is_abs) begin
            status_nxt[dsp_pkg::ST_AS_BIT] = req.x_operand[15];
            status_nxt[dsp_pkg::ST_AZ_BIT] = (req.x_operand == dsp_pkg::WORD_RST);
            status_nxt[dsp_pkg::ST_AN_BIT] = abs_value[15];
            // 8000h has no positive twin in 16 bits
            status_nxt[dsp_pkg::ST_AV_BIT] = (req.x_operand == dsp_pkg::MOST_NEG);
        end else if (is_stat_wr) begin
            // A plain write of 4h is how a caller reports overflow or divide by zero
            status_nxt = req.wdata[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_r <= dsp_pkg::STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Result group: written only by the absolute value operation
    always_comb begin
        result_nxt = result_r;
        if (is_abs) begin
            result_nxt = abs_value;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_r <= dsp_pkg::WORD_RST;
        end else begin
            result_r <= result_nxt;
        end
    end

    // Product words: the top word only ever holds the sign of the middle word
    always_comb begin
        mid_nxt = mid_r;
        top_nxt = top_r;
        if (is_mid_wr) begin
            mid_nxt = req.wdata;
            top_nxt = top_fill;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mid_r <= dsp_pkg::WORD_RST;
            top_r <= dsp_pkg::WORD_RST;
        end else begin
            mid_r <= mid_nxt;
            top_r <= top_nxt;
        end
    end

    assign remainder.high = alu_feedback_reg_r;
    assign remainder.low = dividend_low_reg_r;
    assign alu_status_register = status_r;
    assign quotient_bit_flag = status_r[dsp_pkg::ST_AQ_BIT];
    assign alu_overflow_flag = status_r[dsp_pkg::ST_AV_BIT];
    assign alu_result = result_r;
    assign product_middle_word = mid_r;
    assign product_top_word = top_r;
    // Unsigned steps with a divisor above 7FFFh give garbage; flagged, not fixed
    assign unsigned_divisor_invalid = divisor_invalid_r;
endmodule

// *** test/dsp_divide_step_sva.sv ***
// Port-level checker for the divide step datapath
`timescale 1ns/1ps
module dsp_divide_step_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire dsp_pkg::dsp_req_t req,
    input wire dsp_pkg::dsp_rem_t remainder,
    input wire logic [7:0] alu_status_register,
    input wire logic quotient_bit_flag,
    input wire logic alu_overflow_flag,
    input wire logic [15:0] alu_result,
    input wire logic [15:0] product_middle_word,
    input wire logic [15:0] product_top_word,
    input wire logic unsigned_divisor_invalid
);
    wire sgn = req.op == dsp_pkg::DSP_OP_SIGN;
    wire qb = req.op == dsp_pkg::DSP_OP_QBIT;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_sign_flag_xor: assert property (sgn |=> quotient_bit_flag ==
        ($past(req.x_operand[15]) ^ $past(req.y_high[15]))) else $error("sign step flag");
    a_sign_shift_words: assert property (sgn |=> remainder.high ==
        {$past(req.y_high[14:0]), $past(req.y_low[15])}
        && remainder.low == {$past(req.y_low[14:0]), quotient_bit_flag}) else $error("sign step shift");
    a_qbit_shift_in: assert property (qb |=> remainder.high[0] == $past(remainder.low[15])
        && remainder.low == {$past(remainder.low[14:0]), !quotient_bit_flag}) else $error("bit step shift");
    a_abs_most_neg: assert property (req.op == dsp_pkg::DSP_OP_ABS && req.x_operand == 16'h8000
        |=> alu_overflow_flag && alu_result == 16'h8000) else $error("abs overflow");
    a_status_write: assert property (req.op == dsp_pkg::DSP_OP_STAT_WR
        |=> alu_status_register == $past(req.wdata[7:0])) else $error("status write");
    a_flag_mirror: assert property (alu_overflow_flag == alu_status_register[2]
        && quotient_bit_flag == alu_status_register[5]) else $error("flag mirror");
    a_mid_extend: assert property (req.op == dsp_pkg::DSP_OP_MID_WR |=>
        product_top_word == {16{$past(req.wdata[15])}}) else $error("top word extend");
    a_divisor_invalid: assert property (qb |=>
        unsigned_divisor_invalid == $past(req.x_operand[15])) else $error("divisor invalid");
endmodule
bind dsp_divide_step dsp_divide_step_sva i_sva (.mclk, .rst, .req, .remainder,
    .alu_status_register, .quotient_bit_flag, .alu_overflow_flag, .alu_result,
    .product_middle_word, .product_top_word, .unsigned_divisor_invalid);

// *** test/dsp_divide_step_test.sv ***
// Self-checking bench for the divide step datapath
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %h, seen %h", n, e, a); end end
module dsp_divide_step_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    dsp_pkg::dsp_req_t req = '0;
    dsp_pkg::dsp_rem_t remainder;
    logic [7:0] alu_status_register;
    logic quotient_bit_flag, alu_overflow_flag, unsigned_divisor_invalid;
    logic [15:0] alu_result, product_middle_word, product_top_word, mh, ml, s, w;
    logic mq = 1'b0;
    logic mv = 1'b0;
    int num_errors = 0;
    int compares = 0;
    dsp_divide_step i_dut (.mclk, .rst, .req, .remainder, .alu_status_register,
        .quotient_bit_flag, .alu_overflow_flag, .alu_result, .product_middle_word,
        .product_top_word, .unsigned_divisor_invalid);
    always #20 mclk = ~mclk;
    task automatic test_done;
        $display("errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Drives one request and advances the bit-accurate reference alongside it
    task automatic step(input dsp_pkg::dsp_op_t o, input logic [15:0] x, yh, yl, wd);
        @(negedge mclk);
        req <= '{o, x, yh, yl, wd};
        case (o)
            dsp_pkg::DSP_OP_SIGN: begin
                mq = x[15] ^ yh[15];
                mh = {yh[14:0], yl[15]};
                ml = {yl[14:0], mq};
            end
            dsp_pkg::DSP_OP_QBIT: begin
                s = mq ? mh + x : mh - x;
                mv = mv | ((mh[15] == (x[15] ^ !mq)) && (s[15] != mh[15]));
                mq = x[15] ^ s[15];
                mh = {s[14:0], ml[15]};
                ml = {ml[14:0], ~mq};
            end
            dsp_pkg::DSP_OP_LOAD: begin
                mh = yh;
                ml = yl;
            end
            dsp_pkg::DSP_OP_STAT_WR: begin
                mq = wd[5];
                mv = wd[2];
            end
            dsp_pkg::DSP_OP_ABS: mv = (x == 16'h8000);
            default: ;
        endcase
    endtask
    task automatic divide(input logic uns, input logic [15:0] x, yh, yl);
        if (uns) begin
            step(dsp_pkg::DSP_OP_LOAD, 16'h0000, yh, yl, 16'h0000);
            step(dsp_pkg::DSP_OP_STAT_WR, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        end else begin
            step(dsp_pkg::DSP_OP_SIGN, x, yh, yl, 16'h0000);
        end
        for (int i = 0; i < 15 + uns; i++) begin
            step(dsp_pkg::DSP_OP_QBIT, x, 16'h0000, 16'h0000, 16'h0000);
        end
        step(dsp_pkg::DSP_OP_NONE, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        `CHK("quotient", ml, remainder.low)
        `CHK("quotient flag", mq, quotient_bit_flag)
        `CHK("divisor invalid", x[15], unsigned_divisor_invalid)
        `CHK("step overflow", mv, alu_overflow_flag)
        `CHK("x sign", uns ? 1'b0 : x[15], alu_status_register[dsp_pkg::ST_AS_BIT])
    endtask
    initial begin
        void'($urandom(32'h976D4B02));
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst <= 1'b0;
        divide(1'b0, 16'hC000, 16'h4000, 16'h0000);
        `CHK("most negative quotient", 16'h8000, remainder.low)
        divide(1'b0, 16'hC000, 16'h2000, 16'h0000);
        `CHK("negative divisor quotient", 16'hBFFF, remainder.low)
        divide(1'b1, 16'h8001, 16'h0001, 16'h2345);
        divide(1'b1, 16'h4000, 16'h1234, 16'hFFFF);
        for (int k = 0; k < 24; k++) begin
            divide(k[0], 16'($urandom), 16'($urandom), 16'($urandom));
        end
        step(dsp_pkg::DSP_OP_ABS, 16'h8000, 16'h0000, 16'h0000, 16'h0000);
        step(dsp_pkg::DSP_OP_NONE, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        `CHK("abs overflow", 1'b1, alu_overflow_flag)
        `CHK("abs result", 16'h8000, alu_result)
        `CHK("abs x sign", 1'b1, alu_status_register[dsp_pkg::ST_AS_BIT])
        `CHK("abs negative", 1'b1, alu_status_register[dsp_pkg::ST_AN_BIT])
        `CHK("abs zero", 1'b0, alu_status_register[dsp_pkg::ST_AZ_BIT])
        step(dsp_pkg::DSP_OP_STAT_WR, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        step(dsp_pkg::DSP_OP_NONE, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        `CHK("cleared overflow", 1'b0, alu_overflow_flag)
        step(dsp_pkg::DSP_OP_STAT_WR, 16'h0000, 16'h0000, 16'h0000, 16'h0004);
        step(dsp_pkg::DSP_OP_NONE, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        `CHK("status", 8'h04, alu_status_register)
        `CHK("status overflow", 1'b1, alu_overflow_flag)
        for (int k = 0; k < 4; k++) begin
            w = (k == 0) ? 16'h8001 : 16'($urandom);
            step(dsp_pkg::DSP_OP_MID_WR, 16'h0000, 16'h0000, 16'h0000, w);
            step(dsp_pkg::DSP_OP_NONE, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
            `CHK("middle word", w, product_middle_word)
            `CHK("top word", {16{w[15]}}, product_top_word)
        end
        test_done;
    end
    // About ten times the longest expected run, so only a hang reaches it
    initial begin
        #200000;
        num_errors++;
        test_done;
    end
endmodule
